//--- common/strap_defs.vh
/*
  Constants for the strap option latch: register byte offsets on APB,
  field positions inside those registers, reset images and the settle
  count used before the strap pins are trusted.
  Assumes plain Verilog-2005 and inclusion by bare name.
*/
`ifndef STRAP_DEFS_VH
`define STRAP_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_MODE_CTRL 8'h00
`define OFS_ADVERT 8'h04
`define OFS_PHY_CTRL 8'h08
`define OFS_STRAP_STATUS 8'h0C

// ****************************************************************
// Basic mode control fields
// ****************************************************************
`define MC_RESET_BIT 15
`define MC_SPEED_BIT 13
`define MC_AN_BIT 12
`define MC_ISO_BIT 10
`define MC_DUPLEX_BIT 8
`define MC_WR_MASK 16'h3500

// ****************************************************************
// Advertisement fields: ability bits 8..5 = 100FD, 100HD, 10FD, 10HD
// ****************************************************************
`define ADV_ABIL_LSB 5
`define ADV_ABIL_MSB 8
`define ADV_SELECTOR 16'h0001
`define ADV_WR_MASK 16'h01E0

// ****************************************************************
// Status fields
// ****************************************************************
`define ST_CAPTURED_BIT 15
`define ST_FIBER_N_BIT 8
`define ST_AN_BIT 7
`define ST_MSH_BIT 6
`define ST_MSL_BIT 5

// ****************************************************************
// Strap defaults with no resistors fitted, and reset images
// ****************************************************************
`define DEF_ADDR 5'h01
`define DEF_AN 1'b1
`define DEF_MSH 1'b1
`define DEF_MSL 1'b1
`define DEF_FIBER_N 1'b1
`define RST_MODE_CTRL 16'h3100
`define RST_ADVERT 16'h01E1

// ****************************************************************
// Cycles to wait after reset release before sampling the pins
// ****************************************************************
`define STRAP_SETTLE_CYC 2'h3

`endif

//--- design/strap_sync.v
/*
  Three-stage synchroniser for the strap pins, one bank for all bits.
  Assumes pins are asynchronous to pclk; reports a level as steady only
  when the second and third stages agree.
*/
`timescale 1ns/100ps

module strap_sync #(
  parameter WIDTH = 9
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level,
  output wire steady
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // First stage feeds only the second, to contain metastability
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= {WIDTH{1'b0}};
      stage2_r <= {WIDTH{1'b0}};
      stage3_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A level counts only once the last two stages agree
  assign level = stage3_r;
  assign steady = (stage2_r == stage3_r);

endmodule

//--- design/strap_option_latch.v
/*
  Strap option latch: samples the strap pins once after each hardware
  reset, keeps the captured levels, and seeds the mode control,
  advertisement and PHY control registers from them. Software reaches
  the registers over APB with zero wait states.
  Assumes presetn is the power-up and hardware reset, strap resistors
  hold the pins while presetn is low and for a few cycles after, and
  the pin drivers stay off until straps_captured rises.
*/
// Added by the designer: the APB register port and the address map.
// Function
// - Sample all straps at power-up and hardware reset
// - Software reset reloads captured values, no resample
// - Latch five address straps into PHY control
// - Accept addresses 0 to 31, match latched address
// - Strapped address zero enters isolate after reset
// - Software-written address zero never isolates
// - Address default is one without resistors
// - Negotiation strap enables negotiation or forces mode
// - Mode straps set advertised or forced mode
// - Straps seed mode control and advertisement registers
// - Negotiation and mode straps default to ones
// - Fiber strap low: 100 Mb, low strap duplex
// - Fiber ignores negotiation and high mode straps
// - Forced pair selects 10/100 and half/full duplex
`timescale 1ns/100ps
`include "strap_defs.vh"

module strap_option_latch #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [4:0] station_address_strap,
  input wire negotiation_enable_strap,
  input wire mode_select_high_strap,
  input wire mode_select_low_strap,
  input wire fiber_select_strap_n,
  input wire [4:0] mgmt_addr,
  output wire mgmt_addr_match,
  output wire [4:0] station_address,
  output wire isolate,
  output wire an_enable,
  output wire speed_100,
  output wire full_duplex,
  output wire fiber_mode,
  output wire [3:0] advert_ability,
  output wire straps_captured
);

  // ****************************************************************
  // Register selects
  // ****************************************************************
  localparam SEL_NONE = 3'd0;
  localparam SEL_MODE = 3'd1;
  localparam SEL_ADV = 3'd2;
  localparam SEL_PHY = 3'd3;
  localparam SEL_STAT = 3'd4;

  // Capture sequencer states
  localparam ST_SETTLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_HELD = 2'd2;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [8:0] pin_level;
  wire pin_steady;
  wire capture_now;
  wire setup_phase;
  wire wr_access;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] settle_cnt_r;
  reg [4:0] cap_addr_r;
  reg cap_an_r;
  reg cap_msh_r;
  reg cap_msl_r;
  reg cap_fiber_n_r;
  reg soft_rst_r;
  reg [15:0] mode_ctrl_r;
  reg [15:0] advert_r;
  reg [4:0] phy_addr_r;
  reg [31:0] rd_data;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Address decode, shared by read setup and write access
  function [2:0] reg_sel;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `OFS_MODE_CTRL: reg_sel = SEL_MODE;
        `OFS_ADVERT: reg_sel = SEL_ADV;
        `OFS_PHY_CTRL: reg_sel = SEL_PHY;
        `OFS_STRAP_STATUS: reg_sel = SEL_STAT;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Mode control image from strap levels
  function [15:0] ctrl_image;
    input an;
    input msh;
    input msl;
    input fib_n;
    input [4:0] addr;
    begin
      ctrl_image = 16'h0000;
      // Fiber never negotiates and ignores the high mode strap
      ctrl_image[`MC_AN_BIT] = an & fib_n;
      ctrl_image[`MC_SPEED_BIT] = fib_n ? msh : 1'b1;
      ctrl_image[`MC_DUPLEX_BIT] = msl;
      ctrl_image[`MC_ISO_BIT] = (addr == 5'h00);
    end
  endfunction

  // Advertisement image from strap levels
  function [15:0] adv_image;
    input msh;
    input msl;
    input fib_n;
    reg [3:0] abil;
    begin
      abil = 4'h0;
      if (!fib_n) begin
        // Fiber offers 100 Mb only, duplex from the low strap
        abil = msl ? 4'h8 : 4'h4;
      end else begin
        case ({msh, msl})
          2'b00: abil = 4'h1;
          2'b01: abil = 4'h2;
          2'b10: abil = 4'h4;
          2'b11: abil = 4'hF;
          default: abil = 4'h0;
        endcase
      end
      adv_image = `ADV_SELECTOR;
      adv_image[`ADV_ABIL_MSB:`ADV_ABIL_LSB] = abil;
    end
  endfunction

  // ****************************************************************
  // Strap pin synchroniser
  // ****************************************************************
  // Bits: 8 fiber_n, 7 neg enable, 6 mode high, 5 mode low, 4..0 address
  strap_sync #(
    .WIDTH(9)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({fiber_select_strap_n, negotiation_enable_strap,
             mode_select_high_strap, mode_select_low_strap,
             station_address_strap}),
    .level(pin_level),
    .steady(pin_steady)
  );

  // ****************************************************************
  // Capture sequencer
  // ****************************************************************
  // Settle lets the chain fill with real pin levels before any sample
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_cnt_r == `STRAP_SETTLE_CYC) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (pin_steady) begin
          state_nxt = ST_HELD;
        end
      end
      ST_HELD: begin
        state_nxt = ST_HELD;
      end
      default: begin
        state_nxt = ST_SETTLE;
      end
    endcase
  end

  assign capture_now = (state_r == ST_WAIT) && pin_steady;

  // Sequencer state and settle counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_SETTLE;
      settle_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_SETTLE) begin
        settle_cnt_r <= settle_cnt_r + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Captured strap values
  // ****************************************************************
  // Defaults match the internal pulls, so a read before capture agrees
  // with an unstrapped board; only a hardware reset clears them again
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_addr_r <= `DEF_ADDR;
      cap_an_r <= `DEF_AN;
      cap_msh_r <= `DEF_MSH;
      cap_msl_r <= `DEF_MSL;
      cap_fiber_n_r <= `DEF_FIBER_N;
    end else if (capture_now) begin
      cap_addr_r <= pin_level[4:0];
      cap_an_r <= pin_level[7];
      cap_msh_r <= pin_level[6];
      cap_msl_r <= pin_level[5];
      cap_fiber_n_r <= pin_level[8];
    end
  end

  // ****************************************************************
  // APB access decode
  // ****************************************************************
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign wr_sel = reg_sel(paddr);
  assign rd_sel = reg_sel(paddr);
  // Zero wait states: every access phase completes at once
  assign pready = psel & penable;

  // Software reset request, one cycle after the write that sets it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_access && (wr_sel == SEL_MODE) &&
                    pwdata[`MC_RESET_BIT];
    end
  end

  // ****************************************************************
  // Mode control, advertisement and PHY control registers
  // ****************************************************************
  // Capture and software reload win over a write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_r <= `RST_MODE_CTRL;
      advert_r <= `RST_ADVERT;
      phy_addr_r <= `DEF_ADDR;
    end else if (capture_now) begin
      mode_ctrl_r <= ctrl_image(pin_level[7], pin_level[6],
                                pin_level[5], pin_level[8],
                                pin_level[4:0]);
      advert_r <= adv_image(pin_level[6], pin_level[5],
                            pin_level[8]);
      phy_addr_r <= pin_level[4:0];
    end else if (soft_rst_r) begin
      // Reload from the held copies; the pins are not looked at
      mode_ctrl_r <= ctrl_image(cap_an_r, cap_msh_r, cap_msl_r,
                                cap_fiber_n_r, cap_addr_r);
      advert_r <= adv_image(cap_msh_r, cap_msl_r, cap_fiber_n_r);
      phy_addr_r <= cap_addr_r;
    end else if (wr_access) begin
      case (wr_sel)
        SEL_MODE: begin
          mode_ctrl_r <= (mode_ctrl_r & ~`MC_WR_MASK) |
                         (pwdata[15:0] & `MC_WR_MASK);
          mode_ctrl_r[`MC_RESET_BIT] <= pwdata[`MC_RESET_BIT];
          if (!cap_fiber_n_r) begin
            mode_ctrl_r[`MC_AN_BIT] <= 1'b0;
            mode_ctrl_r[`MC_SPEED_BIT] <= 1'b1;
          end
        end
        SEL_ADV: begin
          advert_r <= (advert_r & ~`ADV_WR_MASK) |
                      (pwdata[15:0] & `ADV_WR_MASK);
        end
        SEL_PHY: begin
          // Address zero written here leaves isolate alone
          phy_addr_r <= pwdata[4:0];
        end
        default: begin
          phy_addr_r <= phy_addr_r;
        end
      endcase
    end else begin
      // Reset bit reads back set only while the reload is pending
      mode_ctrl_r[`MC_RESET_BIT] <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @* begin
    rd_data = 32'h0000_0000;
    case (rd_sel)
      SEL_MODE: rd_data[15:0] = mode_ctrl_r;
      SEL_ADV: rd_data[15:0] = advert_r;
      SEL_PHY: rd_data[4:0] = phy_addr_r;
      SEL_STAT: begin
        rd_data[`ST_CAPTURED_BIT] = (state_r == ST_HELD);
        rd_data[`ST_FIBER_N_BIT] = cap_fiber_n_r;
        rd_data[`ST_AN_BIT] = cap_an_r;
        rd_data[`ST_MSH_BIT] = cap_msh_r;
        rd_data[`ST_MSL_BIT] = cap_msl_r;
        rd_data[4:0] = cap_addr_r;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Read data and error are sampled in the setup cycle so that both
  // leave flip-flops during the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= (rd_sel == SEL_NONE);
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  assign station_address = phy_addr_r;
  // Matching uses the live address, any value 0 to 31
  assign mgmt_addr_match = (mgmt_addr == phy_addr_r);
  assign isolate = mode_ctrl_r[`MC_ISO_BIT];
  assign an_enable = mode_ctrl_r[`MC_AN_BIT];
  assign speed_100 = mode_ctrl_r[`MC_SPEED_BIT];
  assign full_duplex = mode_ctrl_r[`MC_DUPLEX_BIT];
  assign fiber_mode = ~cap_fiber_n_r;
  assign advert_ability = advert_r[`ADV_ABIL_MSB:`ADV_ABIL_LSB];
  // Pin drivers may take over only after this rises
  assign straps_captured = (state_r == ST_HELD);

endmodule

//--- testbench/strap_resistors.sv
/*
  Model of the strap resistors on the shared pins.
  Assumes the bench sets fit before reset and raises reuse only after capture.
*/
`timescale 1ns/100ps
module strap_resistors (
  input wire [8:0] fit,
  input wire reuse,
  output wire [4:0] station_address_strap,
  output wire negotiation_enable_strap,
  output wire mode_select_high_strap,
  output wire mode_select_low_strap,
  output wire fiber_select_strap_n
);
  // Reused pins swing away from the strap level, so a resample would show
  assign {fiber_select_strap_n, negotiation_enable_strap, mode_select_high_strap,
    mode_select_low_strap, station_address_strap} = reuse ? ~fit : fit;
endmodule

//--- testbench/strap_option_latch_asserts.sv
/*
  Port checker for the strap option latch.
  Assumes a bind from the bench top and pins steady around capture.
*/
`timescale 1ns/100ps
module strap_option_latch_asserts #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [4:0] station_address_strap,
  input wire negotiation_enable_strap,
  input wire mode_select_high_strap,
  input wire mode_select_low_strap,
  input wire fiber_select_strap_n,
  input wire [4:0] mgmt_addr,
  input wire mgmt_addr_match,
  input wire [4:0] station_address,
  input wire isolate,
  input wire an_enable,
  input wire speed_100,
  input wire full_duplex,
  input wire fiber_mode,
  input wire [3:0] advert_ability,
  input wire straps_captured
);
  // ****************************************************************
  // Capture and hold checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_bound: assert property ($rose(presetn) |-> ##[1:12] straps_captured)
    else $error("straps not captured in time");
  a_addr_capture: assert property ($rose(straps_captured) |-> station_address == station_address_strap)
    else $error("address not latched");
  a_match_addr: assert property (mgmt_addr_match == (mgmt_addr == station_address))
    else $error("address match wrong");
  a_iso_strap: assert property ($rose(straps_captured) |-> isolate == (station_address_strap == 5'h00))
    else $error("isolate not from strap");
  a_no_soft_iso: assert property (psel && penable && pwrite && paddr == 8'h08 && !isolate && straps_captured
    |=> !isolate) else $error("address write isolated");
  a_an_strap: assert property ($rose(straps_captured)
    |-> an_enable == (negotiation_enable_strap && fiber_select_strap_n)) else $error("negotiation wrong");
  a_advert_neg: assert property ($rose(straps_captured) && negotiation_enable_strap && fiber_select_strap_n
    |-> advert_ability == (mode_select_high_strap && mode_select_low_strap ? 4'hF :
    4'h1 << {mode_select_high_strap, mode_select_low_strap})) else $error("advert wrong");
  a_fiber_mode: assert property ($rose(straps_captured) && !fiber_select_strap_n
    |-> fiber_mode && full_duplex == mode_select_low_strap) else $error("fiber mode wrong");
  a_fiber_no_neg: assert property (fiber_mode |-> !an_enable && speed_100)
    else $error("fiber negotiates");
  a_forced_mode: assert property ($rose(straps_captured) && fiber_select_strap_n && !negotiation_enable_strap
    |-> {speed_100, full_duplex} == {mode_select_high_strap, mode_select_low_strap}) else $error("forced wrong");
  a_capture_holds: assert property (straps_captured |=> straps_captured && $stable(fiber_mode))
    else $error("capture lost");

  c_iso: cover property ($rose(straps_captured) && isolate);
  c_fiber: cover property ($rose(straps_captured) && fiber_mode);
  c_err: cover property (psel && penable && pslverr);
endmodule

//--- testbench/strap_option_latch_tb.sv
/*
  Bench for the strap option latch: APB tasks, strap setups, checks.
  Assumes zero wait state APB and the resistor model beside the design.
*/
`timescale 1ns/100ps
`include "strap_defs.vh"
module strap_option_latch_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [4:0] mgmt_addr = 5'h00;
  reg [8:0] fit = 9'h1E1;
  reg reuse = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, isolate, an_enable, speed_100, full_duplex, fiber_mode, straps_captured;
  wire [4:0] station_address_strap, station_address;
  wire negotiation_enable_strap, mode_select_high_strap, mode_select_low_strap, fiber_select_strap_n;
  wire mgmt_addr_match;
  wire [3:0] advert_ability;
  integer err_count = 0;
  integer compares = 0;
  integer i;
  reg [31:0] rd;
  reg rerr;

  always #20 pclk = ~pclk;

  strap_resistors straps (.fit(fit), .reuse(reuse), .station_address_strap(station_address_strap),
    .negotiation_enable_strap(negotiation_enable_strap), .mode_select_high_strap(mode_select_high_strap),
    .mode_select_low_strap(mode_select_low_strap), .fiber_select_strap_n(fiber_select_strap_n));

  strap_option_latch dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .station_address_strap(station_address_strap), .negotiation_enable_strap(negotiation_enable_strap),
    .mode_select_high_strap(mode_select_high_strap), .mode_select_low_strap(mode_select_low_strap),
    .fiber_select_strap_n(fiber_select_strap_n), .mgmt_addr(mgmt_addr), .mgmt_addr_match(mgmt_addr_match),
    .station_address(station_address), .isolate(isolate), .an_enable(an_enable), .speed_100(speed_100),
    .full_duplex(full_duplex), .fiber_mode(fiber_mode), .advert_ability(advert_ability),
    .straps_captured(straps_captured));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Request held until pready is seen high; data taken at that edge
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (pready !== 1'b1) begin
        err_count = err_count + 1;
        complete_run;
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the updates of the access edge land before callers look at outputs
      @(posedge pclk);
    end
  endtask

  // Pins settle before reset and stay put through capture
  task hw_reset(input [8:0] f);
    integer n;
    begin
      @(posedge pclk);
      reuse <= 1'b0;
      fit <= f;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (straps_captured !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (straps_captured !== 1'b1) begin
        err_count = err_count + 1;
        complete_run;
      end
    end
  endtask

  function [3:0] adv(input [1:0] m);
    adv = (m == 2'b11) ? 4'hF : 4'h1 << m;
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    hw_reset(9'h1E1);
    apb(1'b0, `OFS_MODE_CTRL, 32'h0);
    check(rd, 32'h3100);
    apb(1'b0, `OFS_STRAP_STATUS, 32'h0);
    check(rd, 32'h81E1);
    // Every forced and advertised pair, address zero on the first pass
    for (i = 0; i < 8; i = i + 1) begin
      hw_reset({1'b1, i[2:0], 2'b00, i[2:0]});
      check(station_address, i);
      check(isolate, i == 0);
      check(an_enable, i[2]);
      apb(1'b0, i[2] ? `OFS_ADVERT : `OFS_MODE_CTRL, 32'h0);
      if (i[2])
        check(rd, {23'h0, adv(i[1:0]), 5'h01});
      else
        check(rd, {18'h0, i[1], 2'b00, i == 0, 1'b0, i[0], 8'h00});
    end
    // Top address, software zero address, pin reuse and soft reset
    hw_reset(9'h1FF);
    mgmt_addr <= 5'h1F;
    apb(1'b0, `OFS_PHY_CTRL, 32'h0);
    check(rd[4:0], 5'h1F);
    check(mgmt_addr_match, 1'b1);
    mgmt_addr <= 5'h00;
    apb(1'b1, `OFS_PHY_CTRL, 32'h0);
    check(isolate, 1'b0);
    check(mgmt_addr_match, 1'b1);
    reuse <= 1'b1;
    apb(1'b1, `OFS_MODE_CTRL, 32'h0);
    apb(1'b1, `OFS_MODE_CTRL, 32'h8000);
    apb(1'b0, `OFS_MODE_CTRL, 32'h0);
    check(rd, 32'h3100);
    check(mgmt_addr_match, 1'b0);
    apb(1'b1, `OFS_STRAP_STATUS, 32'h0);
    apb(1'b0, `OFS_STRAP_STATUS, 32'h0);
    check(rd, 32'h81FF);
    apb(1'b0, 8'h10, 32'h0);
    check(rerr, 1'b1);
    check(rd, 32'h0);
    // Fiber with either duplex; negotiation stays off even when written
    for (i = 0; i < 2; i = i + 1) begin
      hw_reset({3'b010, i[0], 5'h03});
      check({fiber_mode, speed_100, full_duplex}, {2'b11, i[0]});
      apb(1'b1, `OFS_MODE_CTRL, 32'h1000);
      check(an_enable, 1'b0);
      apb(1'b0, `OFS_ADVERT, 32'h0);
      check(rd, {23'h0, i[0] ? 4'h8 : 4'h4, 5'h01});
      check(advert_ability, i[0] ? 4'h8 : 4'h4);
    end
    complete_run;
  end
endmodule

bind strap_option_latch strap_option_latch_asserts #(.ADDR_W(ADDR_W)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .station_address_strap(station_address_strap), .negotiation_enable_strap(negotiation_enable_strap),
  .mode_select_high_strap(mode_select_high_strap), .mode_select_low_strap(mode_select_low_strap),
  .fiber_select_strap_n(fiber_select_strap_n), .mgmt_addr(mgmt_addr), .mgmt_addr_match(mgmt_addr_match),
  .station_address(station_address), .isolate(isolate), .an_enable(an_enable), .speed_100(speed_100),
  .full_duplex(full_duplex), .fiber_mode(fiber_mode), .advert_ability(advert_ability),
  .straps_captured(straps_captured));
